/* File: tb/heartbeat_and_io_event_framer_test.sv */
// Purpose: Self-checking bench for the heartbeat and event report framer
// Assumes: Short second tick through SEC_CYCLES
// Notes: Event frames are compared whole against a queue model, heartbeat frames against an expected frame built from expAvg, hbRssi and originAddr
`timescale 1ns/1ps

module heartbeat_and_io_event_framer_test;
	integer seed = 43474;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [15:0] heartbeatPeriodSetting = 16'hffff;
	logic [23:0] originAddr = 24'h0;
	logic [7:0] hbRssi = 8'h0;
	logic beaconValid = 1'b0;
	logic [7:0] beaconPower = 8'h0;
	logic ioEventReq = 1'b0;
	logic ioEventReady;
	logic [7:0] evtRssi = 8'h0;
	logic [5:0] gpioLevels = 6'h0;
	logic [11:0] adc0 = 12'h0, adc1 = 12'h0, adc2 = 12'h0;
	logic [7:0] eventFlags = 8'h0;
	logic [11:0] dac0 = 12'h0, dac1 = 12'h0;
	logic outValid, outReady, outLast, slow = 1'b1, evOn = 1'b0;
	logic [7:0] outData;
	logic gotFrame;
	logic [159:0] gotBytes;
	int gotLen, n_fail = 0, n_checks = 0, hbCount = 0, evCount = 0, i;
	logic [7:0] expAvg = 8'h7f;
	logic [159:0] expQ[$];
	int avg16 = 0, smp;
	logic avgOn = 1'b0, wasTaken = 1'b0;

	initial forever #2 clk = ~clk;

	heartbeat_and_io_event_framer #(.SEC_CYCLES(20), .DEPTH(16)) dut (
		.clk(clk), .rst_b(rst_b),
		.heartbeatPeriodSetting(heartbeatPeriodSetting),
		.originAddr(originAddr), .hbRssi(hbRssi),
		.beaconValid(beaconValid), .beaconPower(beaconPower),
		.ioEventReq(ioEventReq), .ioEventReady(ioEventReady),
		.evtRssi(evtRssi), .gpioLevels(gpioLevels),
		.adc0(adc0), .adc1(adc1), .adc2(adc2), .eventFlags(eventFlags),
		.dac0(dac0), .dac1(dac1), .outValid(outValid),
		.outReady(outReady), .outData(outData), .outLast(outLast)
	);

	host_sink host (
		.clk(clk), .rst_b(rst_b), .slow(slow), .outValid(outValid),
		.outReady(outReady), .outData(outData), .outLast(outLast),
		.gotFrame(gotFrame), .gotBytes(gotBytes), .gotLen(gotLen)
	);

	// ----------------------------------------
	// Checking tasks
	// ----------------------------------------
	task automatic check_frame(input logic [159:0] g, e, input int gl, el);
		n_checks++;
		if (g !== e || gl != el) begin
			n_fail++;
			$display("Error %0t: got %h/%0d want %h/%0d", $time, g, gl, e, el);
		end
	endtask

	task automatic check_count(input int got, lo, hi);
		n_checks++;
		if (got < lo || got > hi) begin
			n_fail++;
			$display("Error %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
		end
	endtask

	task automatic check_bit(input logic got, exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error %0t: bit %b want %b", $time, got, exp);
		end
	endtask

	task automatic final_report;
		if (n_fail == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic drain;
		for (i = 0; i < 20000 && expQ.size() > 0; i++)
			@(posedge clk);
		repeat (60) @(posedge clk);
	endtask

	// ----------------------------------------
	// Event stimulus and model
	// ----------------------------------------
	always @(posedge clk) begin
		if (beaconValid && beaconPower !== 8'h7f) begin
			smp = $signed(beaconPower) * 16;
			avg16 = avgOn ? avg16 + ((smp - avg16) >>> 4) : smp;
			avgOn = 1'b1;
		end
	end

	always @(posedge clk) begin
		if (wasTaken)
			check_bit(ioEventReady, 1'b0);
		wasTaken <= ioEventReq && ioEventReady;
		if (ioEventReq && ioEventReady) begin
			evCount++;
			expQ.push_back({4'h0, dac1, 4'h0, dac0, 8'h00, eventFlags,
				4'h0, adc2, 4'h0, adc1, 4'h0, adc0, 2'b00, gpioLevels,
				evtRssi, originAddr, 8'h28, 8'h12, 8'hfb});
			evtRssi <= 8'($random(seed));
			gpioLevels <= 6'($random(seed));
			adc0 <= 12'($random(seed));
			adc1 <= 12'($random(seed));
			adc2 <= 12'($random(seed));
			eventFlags <= 8'($random(seed));
			dac0 <= 12'($random(seed));
			dac1 <= 12'($random(seed));
		end
		ioEventReq <= evOn;
	end

	always @(posedge clk) begin
		if (gotFrame) begin
			if (gotBytes[23:16] === 8'h27) begin
				hbCount++;
				check_frame(gotBytes, {88'h0, expAvg, hbRssi, originAddr, 8'ha8, 8'h27, 8'h07, 8'hfb}, gotLen, 9);
			end else if (expQ.size() == 0) begin
				check_frame(gotBytes, '0, gotLen, 0);
			end else begin
				check_frame(gotBytes, expQ.pop_front(), gotLen, 20);
			end
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		originAddr <= 24'($random(seed));
		hbRssi <= 8'($random(seed));
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		evOn <= 1'b1;
		for (i = 0; i < 5000 && evCount < 20; i++)
			@(posedge clk);
		evOn <= 1'b0;
		drain();
		check_count(hbCount, 1, 1);
		heartbeatPeriodSetting <= 16'h0000;
		for (i = 0; i < 300; i++) begin
			beaconValid <= 1'($random(seed));
			beaconPower <= 8'($random(seed));
			@(posedge clk);
		end
		beaconValid <= 1'b1;
		beaconPower <= 8'hd8;
		repeat (300) @(posedge clk);
		check_count(hbCount, 1, 1);
		expAvg <= 8'(avg16 >>> 4);
		hbRssi <= 8'h7f;
		slow <= 1'b0;
		heartbeatPeriodSetting <= 16'h0002;
		evOn <= 1'b1;
		repeat (400) @(posedge clk);
		heartbeatPeriodSetting <= 16'h0000;
		evOn <= 1'b0;
		drain();
		check_count(hbCount, 9, 12);
		check_count(expQ.size(), 0, 0);
		final_report();
	end

	initial begin
		#(4 * 40000);
		n_fail++;
		final_report();
	end
endmodule

/* File: tb/host_sink.sv */
// Purpose: Host model that takes framed bytes and hands up whole frames
// Assumes: Byte handshake outValid/outReady on clk
// Notes: slow makes the host stall on most cycles
`timescale 1ns/1ps

module host_sink (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic slow,
	input wire logic outValid,
	output logic outReady,
	input wire logic [7:0] outData,
	input wire logic outLast,
	output logic gotFrame,
	output logic [159:0] gotBytes,
	output int gotLen
);
	integer seed = 11;
	int n;

	// ----------------------------------------
	// Byte collection
	// ----------------------------------------
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			outReady <= 1'b0;
			gotFrame <= 1'b0;
			gotBytes <= '0;
			gotLen <= 0;
			n = 0;
		end else begin
			gotFrame <= 1'b0;
			if (outValid && outReady) begin
				if (n == 0)
					gotBytes <= '0;
				if (n < 20)
					gotBytes[8*n +: 8] <= outData;
				if (outLast) begin
					gotFrame <= 1'b1;
					gotLen <= n + 1;
					n = 0;
				end else begin
					n++;
				end
			end
			if (slow)
				outReady <= (($random(seed) & 3) == 0);
			else
				outReady <= (($random(seed) & 7) != 0);
		end
	end
endmodule

/* File: verilog/framer_pkg.sv */
// Purpose: Constants for the heartbeat and I/O event report framer
// Assumes: 250 MHz system clock
// Notes: Byte positions count from the start-of-message byte
package framer_pkg;
	localparam logic [7:0] SOP = 8'hfb;
	localparam logic [7:0] HB_LEN = 8'h07;
	localparam logic [7:0] HB_TYPE = 8'h27;
	localparam logic [7:0] HB_STATUS = 8'ha8;
	localparam logic [7:0] EVT_LEN = 8'h12;
	localparam logic [7:0] EVT_TYPE = 8'h28;
	localparam logic [7:0] PWR_INVALID = 8'h7f;
	localparam logic [4:0] HB_LAST = 5'h08;
	localparam logic [4:0] EVT_LAST = 5'h13;
	localparam logic [15:0] HB_OFF = 16'h0000;
	localparam logic [15:0] HB_ONCE = 16'hffff;
	// Averaging filter: alpha = 1/16 as a shift, 4 fraction bits
	localparam int AVG_SHIFT = 4;
	localparam int CLK_MHZ = 250;
	localparam int HB_UNIT_MS = 1000;
	localparam int SEC_CYCLES = HB_UNIT_MS * 1000 * CLK_MHZ;
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_WIDTH = 9;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_HB = 3'b010,
		ST_EVT = 3'b100
	} state_t;
endpackage

/* File: verilog/heartbeat_and_io_event_framer.sv */
// Behaviour
// R1: Every message starts with byte fb.
// R2: Heartbeat length byte is 07.
// R3: Heartbeat packet type is 27.
// R4: Heartbeat status byte is a8.
// R5: Heartbeat address bytes 04-06, low first.
// R6: Heartbeat byte 07 holds packet power.
// R7: Byte 08 holds 1/16-averaged beacon power.
// R8: Event report length 12, type 28.
// R9: Event report address bytes 03-05, low first.
// R10: Event report byte 06 holds packet power.
// R11: Byte 07 holds input levels 0-5.
// R12: Three 12-bit analog readings, low byte first.
// R13: Trigger-cause flags at bytes 0e-0f.
// R14: Trigger-cause bits 8-15 always zero.
// R15: Two 12-bit output settings, low first.
// R16: Period 0 off, ffff boot only, else seconds.
// R17: Messages sent whole, in order, never interleaved.
//
// Purpose: Frames heartbeat and I/O event report messages into a byte FIFO
// Assumes: All inputs synchronous to clk
// Notes: outLast marks the final byte of each message
`timescale 1ns/1ps

module byte_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_r;
	logic [AW-1:0] rdPtr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	assign inReady = (count_r != (AW+1)'(DEPTH));
	assign push = inValid && inReady;
	assign pop = (count_r != '0) && (!outValid || outReady);

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_r] <= inData;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wrPtr_r <= wrPtr_r + AW'(1);
			end
			if (pop) begin
				rdPtr_r <= rdPtr_r + AW'(1);
			end
			count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Output stage register
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			outValid <= 1'b0;
			outData <= '0;
		end else if (pop) begin
			outValid <= 1'b1;
			outData <= mem[rdPtr_r];
		end else if (outReady) begin
			outValid <= 1'b0;
		end
	end
endmodule

module heartbeat_and_io_event_framer #(
	parameter int SEC_CYCLES = framer_pkg::SEC_CYCLES,
	parameter int DEPTH = framer_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [15:0] heartbeatPeriodSetting,
	input wire logic [23:0] originAddr,
	input wire logic [7:0] hbRssi,
	input wire logic beaconValid,
	input wire logic [7:0] beaconPower,
	input wire logic ioEventReq,
	output logic ioEventReady,
	input wire logic [7:0] evtRssi,
	input wire logic [5:0] gpioLevels,
	input wire logic [11:0] adc0,
	input wire logic [11:0] adc1,
	input wire logic [11:0] adc2,
	input wire logic [7:0] eventFlags,
	input wire logic [11:0] dac0,
	input wire logic [11:0] dac1,
	output logic outValid,
	input wire logic outReady,
	output logic [7:0] outData,
	output logic outLast
);
	framer_pkg::state_t state_r;
	logic [4:0] idx_r;
	logic [31:0] tickCnt_r;
	logic [15:0] secCnt_r;
	logic bootHb_r;
	logic hbPend_r;
	logic secTick;
	logic signed [11:0] avg_r;
	logic avgValid_r;
	logic signed [11:0] sampleFx;
	logic signed [12:0] avgDiff;
	logic [23:0] hbAddr_r;
	logic [7:0] hbRssi_r;
	logic [7:0] hbAvg_r;
	logic [23:0] evAddr_r;
	logic [7:0] evRssi_r;
	logic [5:0] evGpio_r;
	logic [11:0] evAdc0_r;
	logic [11:0] evAdc1_r;
	logic [11:0] evAdc2_r;
	logic [7:0] evFlags_r;
	logic [11:0] evDac0_r;
	logic [11:0] evDac1_r;
	logic evAccept;
	logic [7:0] wrByte;
	logic wrLast;
	logic wrValid;
	logic wrReady;
	logic wrFire;
	logic [8:0] fifoOut;

	// ------------------------------------------------------------
	// Heartbeat timing
	// ------------------------------------------------------------
	assign secTick = (tickCnt_r == 32'(SEC_CYCLES - 1));

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tickCnt_r <= '0;
		end else if (secTick) begin
			tickCnt_r <= '0;
		end else begin
			tickCnt_r <= tickCnt_r + 32'h1;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			secCnt_r <= '0;
			bootHb_r <= 1'b1;
			hbPend_r <= 1'b0;
		end else begin
			bootHb_r <= 1'b0;
			if (heartbeatPeriodSetting == framer_pkg::HB_OFF ||
			    heartbeatPeriodSetting == framer_pkg::HB_ONCE) begin
				secCnt_r <= '0; // [R16]
			end else if (secTick) begin
				secCnt_r <= (secCnt_r + 16'h1 >= heartbeatPeriodSetting) ?
					16'h0 : secCnt_r + 16'h1;
			end
			// Set wins over the clear on frame start
			if (heartbeatPeriodSetting != framer_pkg::HB_OFF &&
			    (bootHb_r || (heartbeatPeriodSetting != framer_pkg::HB_ONCE
			    && secTick && secCnt_r + 16'h1 >= heartbeatPeriodSetting)))
				begin
				hbPend_r <= 1'b1; // [R16]
			end else if (state_r == framer_pkg::ST_IDLE) begin
				hbPend_r <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Beacon power averaging
	// ------------------------------------------------------------
	assign sampleFx = 12'(signed'(beaconPower)) <<< framer_pkg::AVG_SHIFT;
	// One bit wider so a full-scale swing cannot wrap
	assign avgDiff = 13'(sampleFx) - 13'(avg_r);

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			avg_r <= '0;
			avgValid_r <= 1'b0;
		end else if (beaconValid && beaconPower != framer_pkg::PWR_INVALID)
			begin
			avgValid_r <= 1'b1;
			if (!avgValid_r) begin
				avg_r <= sampleFx;
			end else begin
				avg_r <= avg_r + 12'(avgDiff >>>
					framer_pkg::AVG_SHIFT); // [R7]
			end
		end
	end

	// ------------------------------------------------------------
	// Event report capture
	// ------------------------------------------------------------
	assign evAccept = ioEventReq && ioEventReady;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ioEventReady <= 1'b1;
			evAddr_r <= '0;
			evRssi_r <= '0;
			evGpio_r <= '0;
			evAdc0_r <= '0;
			evAdc1_r <= '0;
			evAdc2_r <= '0;
			evFlags_r <= '0;
			evDac0_r <= '0;
			evDac1_r <= '0;
		end else if (evAccept) begin
			ioEventReady <= 1'b0;
			evAddr_r <= originAddr;
			evRssi_r <= evtRssi;
			evGpio_r <= gpioLevels;
			evAdc0_r <= adc0;
			evAdc1_r <= adc1;
			evAdc2_r <= adc2;
			evFlags_r <= eventFlags;
			evDac0_r <= dac0;
			evDac1_r <= dac1;
		end else if (state_r == framer_pkg::ST_EVT && wrFire && wrLast) begin
			ioEventReady <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Framing state machine
	// ------------------------------------------------------------
	assign wrValid = (state_r != framer_pkg::ST_IDLE);
	assign wrFire = wrValid && wrReady;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= framer_pkg::ST_IDLE;
			idx_r <= '0;
			hbAddr_r <= '0;
			hbRssi_r <= '0;
			hbAvg_r <= '0;
		end else begin
			case (state_r)
				framer_pkg::ST_IDLE: begin
					idx_r <= '0;
					if (hbPend_r) begin
						state_r <= framer_pkg::ST_HB;
						hbAddr_r <= originAddr;
						hbRssi_r <= hbRssi; // [R6]
						hbAvg_r <= avgValid_r ?
							8'(avg_r >>> framer_pkg::AVG_SHIFT) :
							framer_pkg::PWR_INVALID; // [R7]
					end else if (!ioEventReady) begin
						state_r <= framer_pkg::ST_EVT;
					end
				end
				framer_pkg::ST_HB, framer_pkg::ST_EVT: begin
					if (wrFire) begin
						idx_r <= idx_r + 5'h1; // [R17]
						if (wrLast) begin
							state_r <= framer_pkg::ST_IDLE;
						end
					end
				end
				default: begin
					state_r <= framer_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Byte at the current position
	always_comb begin
		wrByte = 8'h00;
		wrLast = 1'b0;
		if (state_r == framer_pkg::ST_HB) begin
			wrLast = (idx_r == framer_pkg::HB_LAST);
			case (idx_r)
				5'h00: wrByte = framer_pkg::SOP; // [R1]
				5'h01: wrByte = framer_pkg::HB_LEN; // [R2]
				5'h02: wrByte = framer_pkg::HB_TYPE; // [R3]
				5'h03: wrByte = framer_pkg::HB_STATUS; // [R4]
				5'h04: wrByte = hbAddr_r[7:0]; // [R5]
				5'h05: wrByte = hbAddr_r[15:8]; // [R5]
				5'h06: wrByte = hbAddr_r[23:16]; // [R5]
				5'h07: wrByte = hbRssi_r; // [R6]
				5'h08: wrByte = hbAvg_r; // [R7]
				default: wrByte = 8'h00;
			endcase
		end else if (state_r == framer_pkg::ST_EVT) begin
			wrLast = (idx_r == framer_pkg::EVT_LAST);
			case (idx_r)
				5'h00: wrByte = framer_pkg::SOP; // [R1]
				5'h01: wrByte = framer_pkg::EVT_LEN; // [R8]
				5'h02: wrByte = framer_pkg::EVT_TYPE; // [R8]
				5'h03: wrByte = evAddr_r[7:0]; // [R9]
				5'h04: wrByte = evAddr_r[15:8]; // [R9]
				5'h05: wrByte = evAddr_r[23:16]; // [R9]
				5'h06: wrByte = evRssi_r; // [R10]
				5'h07: wrByte = {2'h0, evGpio_r}; // [R11]
				5'h08: wrByte = evAdc0_r[7:0]; // [R12]
				5'h09: wrByte = {4'h0, evAdc0_r[11:8]}; // [R12]
				5'h0a: wrByte = evAdc1_r[7:0]; // [R12]
				5'h0b: wrByte = {4'h0, evAdc1_r[11:8]}; // [R12]
				5'h0c: wrByte = evAdc2_r[7:0]; // [R12]
				5'h0d: wrByte = {4'h0, evAdc2_r[11:8]}; // [R12]
				5'h0e: wrByte = evFlags_r; // [R13]
				5'h0f: wrByte = 8'h00; // [R14]
				5'h10: wrByte = evDac0_r[7:0]; // [R15]
				5'h11: wrByte = {4'h0, evDac0_r[11:8]}; // [R15]
				5'h12: wrByte = evDac1_r[7:0]; // [R15]
				5'h13: wrByte = {4'h0, evDac1_r[11:8]}; // [R15]
				default: wrByte = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Output buffer
	// ------------------------------------------------------------
	byte_fifo #(
		.WIDTH(framer_pkg::FIFO_WIDTH),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.inValid(wrValid),
		.inReady(wrReady),
		.inData({wrLast, wrByte}),
		.outValid(outValid),
		.outReady(outReady),
		.outData(fifoOut)
	);

	assign outData = fifoOut[7:0];
	assign outLast = fifoOut[8];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_sop_first: assert property (@(posedge clk) disable iff (!rst_b)
		(wrFire && idx_r == 5'h00) |-> wrByte == 8'hfb) // [R1]
		else $error("message does not start with fb");
	a_hb_len: assert property (@(posedge clk) disable iff (!rst_b)
		(state_r == framer_pkg::ST_HB && idx_r == 5'h01) |->
		wrByte == 8'h07) // [R2]
		else $error("heartbeat length wrong");
	a_hb_type: assert property (@(posedge clk) disable iff (!rst_b)
		(state_r == framer_pkg::ST_HB && idx_r == 5'h02) |->
		wrByte == 8'h27) // [R3]
		else $error("heartbeat type wrong");
	a_hb_status: assert property (@(posedge clk) disable iff (!rst_b)
		(state_r == framer_pkg::ST_HB && idx_r == 5'h03) |->
		wrByte == 8'ha8) // [R4]
		else $error("heartbeat status wrong");
	a_hb_addr: assert property (@(posedge clk) disable iff (!rst_b)
		(state_r == framer_pkg::ST_HB && idx_r == 5'h06) |->
		wrByte == hbAddr_r[23:16]) // [R5]
		else $error("heartbeat address order wrong");
	a_evt_header: assert property (@(posedge clk) disable iff (!rst_b)
		(state_r == framer_pkg::ST_EVT && idx_r == 5'h01 && wrFire) |=>
		(wrByte == 8'h28 || !wrFire)) // [R8]
		else $error("event report type wrong");
	a_flags_high: assert property (@(posedge clk) disable iff (!rst_b)
		(state_r == framer_pkg::ST_EVT && idx_r == 5'h0f) |->
		wrByte == 8'h00) // [R14]
		else $error("trigger-cause high byte not zero");
	a_hb_disabled: assert property (@(posedge clk) disable iff (!rst_b)
		(heartbeatPeriodSetting == 16'h0000 && !hbPend_r) |=>
		!hbPend_r) // [R16]
		else $error("heartbeat raised while disabled");
	a_frame_whole: assert property (@(posedge clk) disable iff (!rst_b)
		(wrFire && !wrLast) |=> (state_r == $past(state_r) &&
		idx_r == $past(idx_r) + 5'h1)) // [R17]
		else $error("message interrupted");
endmodule
